// ==== design/gls_pkg.sv ====
package gls_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLOCK_HZ = 100_000_000;
	localparam int TICK_NS = 1_000_000_000;
	localparam int TICK_CYCLES = TICK_NS / (1_000_000_000 / CLOCK_HZ);
	localparam int QUAL_S = 60;
	localparam int ALMANAC_DS = 125;
	localparam int ALMANAC_S = ALMANAC_DS * 60 / 10;
	localparam int LOCK_HOLD_DEFAULT_S = 15 * 60;
	localparam int SYNC_HOLD_DEFAULT_S = 2 * 3600;
	localparam int HOLD_MAX_S = 24 * 3600;
	localparam int FLASH_PERIOD_S = 3;
	localparam int SEC_W = 17;

	// ----------------------------------------
	// display, timecode and output options
	// ----------------------------------------
	typedef enum logic [0:0] {
		GLS_TC_IRIG_B = 1'b0,
		GLS_TC_IRIG_E = 1'b1
	} gls_tc_kind_t;

	typedef enum logic [0:0] {
		GLS_TC_AM = 1'b0,
		GLS_TC_PWC = 1'b1
	} gls_tc_form_t;

	typedef enum logic [0:0] {
		GLS_CARRIER_1000 = 1'b0,
		GLS_CARRIER_100 = 1'b1
	} gls_carrier_t;

	typedef enum logic [0:0] {
		GLS_FREQ_REF = 1'b0,
		GLS_FREQ_TC = 1'b1
	} gls_freq_sel_t;

	typedef struct packed {
		logic fmt_24h;
		logic local_time;
		logic dst_enable;
	} gls_display_format_command_t;

	typedef struct packed {
		gls_tc_kind_t kind;
		gls_tc_form_t form;
		gls_carrier_t carrier;
		logic signature_en;
	} gls_tc_cfg_t;

	typedef struct packed {
		logic minor_alarm;
		logic major_alarm;
	} gls_alarms_t;

	localparam int CABLE_DELAY_W = 16;

endpackage

// ==== design/gls_sec_counter.sv ====
`timescale 1ns/1ns
// saturating seconds counter: counts ticks while run is high, restarts on clear
module gls_sec_counter #(
	parameter int WIDTH = 17
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clear,
	input wire logic i_run,
	input wire logic i_tick,
	output logic [WIDTH-1:0] o_count
);

	initial begin
		if (WIDTH < 2) begin
			$error("gls_sec_counter: WIDTH too small");
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_count <= '0;
		end else if (i_clear) begin
			o_count <= '0;
		end else if (i_run && i_tick && (o_count != '1)) begin
			o_count <= o_count + 1'b1;
		end
	end

endmodule

// ==== design/gls_supervisor.sv ====
`timescale 1ns/1ns
// What this block does
// - lock lamp red at reset, green after one minute of qualified tracking
// - lock holdover defaults to 15 minutes, settable up to 24 hours
// - lock lamp stays green while tracking or within lock holdover
// - no satellite and lock holdover expired: lamp red, minor alarm on
// - one minute of reacquired satellite: lock lamp green, minor alarm off
// - sync lamp red at reset: time not yet synchronised
// - sync lamp green only after satellite and a valid or full 12.5 minute almanac
// - sync holdover defaults to two hours, settable up to 24 hours
// - no satellite and sync holdover expired once sync was green: sync red, major alarm on
// - valid almanac: sync green, major off after one minute of tracking
// - invalid or lost almanac: full almanac recovery before sync green
// - adjust oscillator alarm: display shows all eights every three seconds
// - display offers 12 or 24 hour, UTC or local, DST on or off
// - pulse-per-second leading edge delayed by configured cable offset
// - frequency connector gives 10 MHz or the pulse-width timecode
// - timecode is IRIG B or E, amplitude-modulated or pulse-width
// - signature control removes modulation while lock or sync alarm active
// - AM IRIG E carrier 100 or 1000 Hz; AM IRIG B uses 1000 Hz
module gls_supervisor #(
	parameter int TICK_CYCLES = gls_pkg::TICK_CYCLES,
	parameter int CABLE_DELAY_W = gls_pkg::CABLE_DELAY_W
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	// receiver status
	input wire logic i_sat_qualified,
	input wire logic i_almanac_rx,
	input wire logic i_almanac_valid,
	// holdover configuration, seconds
	input wire logic i_lock_hold_wr,
	input wire logic [gls_pkg::SEC_W-1:0] i_lock_hold_s,
	input wire logic i_sync_hold_wr,
	input wire logic [gls_pkg::SEC_W-1:0] i_sync_hold_s,
	// display
	input wire logic i_adjust_osc_alarm,
	input wire gls_pkg::gls_display_format_command_t i_display_format_command,
	// timing outputs
	input wire logic i_pps_raw,
	input wire logic [CABLE_DELAY_W-1:0] i_cable_delay_command,
	input wire logic i_ref_10mhz,
	input wire logic i_tc_pwc_raw,
	input wire logic i_tc_am_raw,
	input wire gls_pkg::gls_tc_cfg_t i_tc_cfg,
	input wire gls_pkg::gls_freq_sel_t i_freq_sel,
	// status
	output logic o_lock_green,
	output logic o_sync_green,
	output gls_pkg::gls_alarms_t o_alarms,
	output logic o_display_all_eights,
	output gls_pkg::gls_display_format_command_t o_display_format,
	output logic o_pps,
	output logic o_freq_out,
	output logic o_tc_pwc,
	output logic o_tc_am,
	output gls_pkg::gls_tc_cfg_t o_tc_cfg_eff
);

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int SW = gls_pkg::SEC_W;

	initial begin
		if (TICK_CYCLES < 2) begin
			$error("gls_supervisor: TICK_CYCLES too small");
		end
		if (CABLE_DELAY_W < 1 || CABLE_DELAY_W > 24) begin
			$error("gls_supervisor: CABLE_DELAY_W out of range");
		end
		if (gls_pkg::HOLD_MAX_S >= (1 << SW)) begin
			$error("gls_supervisor: SEC_W cannot hold 24 hours");
		end
	end

	// ----------------------------------------
	// one-second tick
	// ----------------------------------------
	logic [TW-1:0] tick_cnt;
	logic tick;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// holdover configuration
	// ----------------------------------------
	logic [SW-1:0] lock_hold;
	logic [SW-1:0] sync_hold;

	// values past 24 hours are clamped rather than refused
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_hold <= SW'(gls_pkg::LOCK_HOLD_DEFAULT_S);
		end else if (i_lock_hold_wr) begin
			lock_hold <= (i_lock_hold_s > SW'(gls_pkg::HOLD_MAX_S)) ? SW'(gls_pkg::HOLD_MAX_S) : i_lock_hold_s;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_hold <= SW'(gls_pkg::SYNC_HOLD_DEFAULT_S);
		end else if (i_sync_hold_wr) begin
			sync_hold <= (i_sync_hold_s > SW'(gls_pkg::HOLD_MAX_S)) ? SW'(gls_pkg::HOLD_MAX_S) : i_sync_hold_s;
		end
	end

	// ----------------------------------------
	// second counters
	// ----------------------------------------
	logic sat_prev;
	logic sat_edge;
	logic [SW-1:0] qual_s;
	logic [SW-1:0] loss_s;
	logic [SW-1:0] alm_s;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sat_prev <= 1'b0;
		end else begin
			sat_prev <= i_sat_qualified;
		end
	end

	assign sat_edge = sat_prev != i_sat_qualified;

	// tracked time, restarted whenever the satellite is gained or lost
	gls_sec_counter #(.WIDTH(SW)) u_qual (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clear(sat_edge),
		.i_run(i_sat_qualified),
		.i_tick(tick),
		.o_count(qual_s)
	);

	// time since last qualified satellite
	gls_sec_counter #(.WIDTH(SW)) u_loss (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clear(sat_edge),
		.i_run(!i_sat_qualified),
		.i_tick(tick),
		.o_count(loss_s)
	);

	// almanac reception time; lost with the almanac itself
	gls_sec_counter #(.WIDTH(SW)) u_alm (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clear(!i_almanac_rx && !i_almanac_valid),
		.i_run(i_almanac_rx && i_sat_qualified),
		.i_tick(tick),
		.o_count(alm_s)
	);

	logic qual_minute;
	logic lock_expired;
	logic sync_expired;
	logic almanac_ok;

	assign qual_minute = i_sat_qualified && (qual_s >= SW'(gls_pkg::QUAL_S));
	// holdover runs from the last tracked second; zero holdover expires at once
	assign lock_expired = !i_sat_qualified && (loss_s >= lock_hold);
	assign sync_expired = !i_sat_qualified && (loss_s >= sync_hold);
	assign almanac_ok = i_almanac_valid || (alm_s >= SW'(gls_pkg::ALMANAC_S));

	// ----------------------------------------
	// lock lamp and minor alarm
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_lock_green <= 1'b0;
			o_alarms.minor_alarm <= 1'b0;
		end else if (qual_minute) begin
			o_lock_green <= 1'b1;
			o_alarms.minor_alarm <= 1'b0;
		end else if (lock_expired) begin
			o_lock_green <= 1'b0;
			o_alarms.minor_alarm <= 1'b1;
		end
	end

	// ----------------------------------------
	// sync lamp and major alarm
	// ----------------------------------------
	// the major alarm is only raised after sync had been reached once
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sync_green <= 1'b0;
			o_alarms.major_alarm <= 1'b0;
		end else if (qual_minute && almanac_ok) begin
			o_sync_green <= 1'b1;
			o_alarms.major_alarm <= 1'b0;
		end else if (sync_expired && o_sync_green) begin
			o_sync_green <= 1'b0;
			o_alarms.major_alarm <= 1'b1;
		end
	end

	// ----------------------------------------
	// display
	// ----------------------------------------
	logic [1:0] flash_s;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flash_s <= '0;
		end else if (!i_adjust_osc_alarm) begin
			flash_s <= '0;
		end else if (tick) begin
			flash_s <= (flash_s == 2'(gls_pkg::FLASH_PERIOD_S - 1)) ? 2'h0 : flash_s + 1'b1;
		end
	end

	// one second of eights in every three
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_display_all_eights <= 1'b0;
		end else begin
			o_display_all_eights <= i_adjust_osc_alarm && (flash_s == 2'h0);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_display_format <= '0;
		end else begin
			o_display_format <= i_display_format_command;
		end
	end

	// ----------------------------------------
	// pulse-per-second delay
	// ----------------------------------------
	// only one pulse edge in flight; delays must stay below one second
	logic pps_prev;
	logic pps_pending;
	logic [CABLE_DELAY_W-1:0] pps_cnt;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pps_prev <= 1'b0;
			pps_pending <= 1'b0;
			pps_cnt <= '0;
			o_pps <= 1'b0;
		end else begin
			pps_prev <= i_pps_raw;
			if (i_pps_raw && !pps_prev) begin
				pps_pending <= 1'b1;
				pps_cnt <= i_cable_delay_command;
			end else if (pps_pending && pps_cnt != '0) begin
				pps_cnt <= pps_cnt - 1'b1;
			end else if (pps_pending) begin
				pps_pending <= 1'b0;
			end
			if (pps_pending && pps_cnt == '0) begin
				o_pps <= 1'b1;
			end else if (!i_pps_raw) begin
				o_pps <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// timecode and frequency connector
	// ----------------------------------------
	gls_pkg::gls_tc_cfg_t next_tc_cfg;
	logic tc_mute;

	always_comb begin
		next_tc_cfg = i_tc_cfg;
		if (i_tc_cfg.kind == gls_pkg::GLS_TC_IRIG_B) begin
			next_tc_cfg.carrier = gls_pkg::GLS_CARRIER_1000;
		end
	end

	assign tc_mute = next_tc_cfg.signature_en && (o_alarms.minor_alarm || o_alarms.major_alarm);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tc_cfg_eff <= '0;
			o_tc_pwc <= 1'b0;
			o_tc_am <= 1'b0;
			o_freq_out <= 1'b0;
		end else begin
			o_tc_cfg_eff <= next_tc_cfg;
			o_tc_pwc <= i_tc_pwc_raw && !tc_mute;
			o_tc_am <= (next_tc_cfg.form == gls_pkg::GLS_TC_AM) && i_tc_am_raw && !tc_mute;
			case (i_freq_sel)
				gls_pkg::GLS_FREQ_TC: begin
					o_freq_out <= i_tc_pwc_raw && !tc_mute;
				end
				default: begin
					o_freq_out <= i_ref_10mhz;
				end
			endcase
		end
	end

endmodule

// ==== sim/gls_rx_model.sv ====
`timescale 1ns/1ns
// receiver stand-in: tracking is reported late, almanac only comes from a tracked satellite
module gls_rx_model #(
	parameter int LAG = 3
) (
	input wire logic i_clock,
	input wire logic i_sat_cmd,
	input wire logic i_rx_cmd,
	input wire logic i_valid_cmd,
	output logic o_sat_qualified,
	output logic o_almanac_rx,
	output logic o_almanac_valid
);
	logic [LAG-1:0] pipe = '0;
	always @(posedge i_clock) begin
		pipe <= {pipe[LAG-2:0], i_sat_cmd};
	end
	assign o_sat_qualified = pipe[LAG-1];
	assign o_almanac_rx = i_rx_cmd && o_sat_qualified;
	assign o_almanac_valid = i_valid_cmd;
endmodule

// ==== sim/gls_supervisor_sva.sv ====
`timescale 1ns/1ns
module gls_supervisor_sva (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_sat_qualified,
	input wire logic i_adjust_osc_alarm,
	input wire gls_pkg::gls_display_format_command_t i_display_format_command,
	input wire logic i_ref_10mhz,
	input wire logic i_tc_pwc_raw,
	input wire gls_pkg::gls_tc_cfg_t i_tc_cfg,
	input wire gls_pkg::gls_freq_sel_t i_freq_sel,
	input wire logic o_lock_green,
	input wire logic o_sync_green,
	input wire gls_pkg::gls_alarms_t o_alarms,
	input wire logic o_display_all_eights,
	input wire gls_pkg::gls_display_format_command_t o_display_format,
	input wire logic o_freq_out,
	input wire logic o_tc_pwc,
	input wire logic o_tc_am,
	input wire gls_pkg::gls_tc_cfg_t o_tc_cfg_eff
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// lamps may only go green behind a satellite that was held before the change
	sequence s_sat_held;
		$past(i_sat_qualified, 2) && $past(i_sat_qualified, 8);
	endsequence
	// three cycles allow for a registered output on the mute path
	sequence s_sig_alarm;
		(i_tc_cfg.signature_en && o_alarms != 2'h0) [*3];
	endsequence
	property p_lock_rise;
		$rose(o_lock_green) |-> s_sat_held;
	endproperty
	property p_minor_red;
		o_alarms.minor_alarm |-> !o_lock_green;
	endproperty
	property p_major_red;
		o_alarms.major_alarm |-> !o_sync_green;
	endproperty
	property p_sync_rise;
		$rose(o_sync_green) |-> s_sat_held;
	endproperty
	property p_sig_mute;
		s_sig_alarm |-> !o_tc_pwc && !o_tc_am;
	endproperty
	property p_freq_ref;
		$past(i_rst_n) && $past(i_freq_sel) == gls_pkg::GLS_FREQ_REF |-> o_freq_out == $past(i_ref_10mhz);
	endproperty
	property p_b_carrier;
		o_tc_cfg_eff.kind == gls_pkg::GLS_TC_IRIG_B |-> o_tc_cfg_eff.carrier == gls_pkg::GLS_CARRIER_1000;
	endproperty
	property p_eights_off;
		!i_adjust_osc_alarm [*3] |-> !o_display_all_eights;
	endproperty
	property p_fmt_copy;
		$past(i_rst_n) |-> o_display_format == $past(i_display_format_command);
	endproperty
	property p_cfg_copy;
		$past(i_rst_n) |-> o_tc_cfg_eff.kind == $past(i_tc_cfg.kind) && o_tc_cfg_eff.form == $past(i_tc_cfg.form)
			&& o_tc_cfg_eff.signature_en == $past(i_tc_cfg.signature_en);
	endproperty
	property p_e_carrier;
		$past(i_rst_n) && $past(i_tc_cfg.kind) == gls_pkg::GLS_TC_IRIG_E |-> o_tc_cfg_eff.carrier == $past(i_tc_cfg.carrier);
	endproperty
	property p_pwc_no_am;
		$past(i_rst_n) && $past(i_tc_cfg.form) == gls_pkg::GLS_TC_PWC |-> !o_tc_am;
	endproperty
	// without alarms nothing is muted, so the mute check above cannot pass on a dead pulse-width output
	property p_pwc_pass;
		$past(i_rst_n) && $past(o_alarms) == 2'h0 |-> o_tc_pwc == $past(i_tc_pwc_raw);
	endproperty
	property p_freq_tc;
		$past(i_rst_n) && $past(i_freq_sel) == gls_pkg::GLS_FREQ_TC && $past(o_alarms) == 2'h0
			|-> o_freq_out == $past(i_tc_pwc_raw);
	endproperty
	a_lock_rise: assert property (p_lock_rise)
		else $error("lock green early");
	a_minor_red: assert property (p_minor_red)
		else $error("minor with lock green");
	a_major_red: assert property (p_major_red)
		else $error("major with sync green");
	a_sync_rise: assert property (p_sync_rise)
		else $error("sync green early");
	a_sig_mute: assert property (p_sig_mute)
		else $error("timecode not muted");
	a_freq_ref: assert property (p_freq_ref)
		else $error("freq out not reference");
	a_b_carrier: assert property (p_b_carrier)
		else $error("irig b carrier wrong");
	a_eights_off: assert property (p_eights_off)
		else $error("eights without alarm");
	a_fmt_copy: assert property (p_fmt_copy)
		else $error("display format not taken");
	a_cfg_copy: assert property (p_cfg_copy)
		else $error("timecode config not taken");
	a_e_carrier: assert property (p_e_carrier)
		else $error("irig e carrier not taken");
	a_pwc_no_am: assert property (p_pwc_no_am)
		else $error("am output in pulse-width form");
	a_pwc_pass: assert property (p_pwc_pass)
		else $error("pulse-width timecode not passed");
	a_freq_tc: assert property (p_freq_tc)
		else $error("freq out not timecode");
endmodule
bind gls_supervisor gls_supervisor_sva u_sva (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_sat_qualified(i_sat_qualified), .i_adjust_osc_alarm(i_adjust_osc_alarm),
	.i_display_format_command(i_display_format_command), .i_ref_10mhz(i_ref_10mhz),
	.i_tc_pwc_raw(i_tc_pwc_raw), .i_tc_cfg(i_tc_cfg), .i_freq_sel(i_freq_sel),
	.o_lock_green(o_lock_green), .o_sync_green(o_sync_green), .o_alarms(o_alarms),
	.o_display_all_eights(o_display_all_eights), .o_display_format(o_display_format),
	.o_freq_out(o_freq_out), .o_tc_pwc(o_tc_pwc), .o_tc_am(o_tc_am), .o_tc_cfg_eff(o_tc_cfg_eff));

// ==== sim/gls_supervisor_tb.sv ====
`timescale 1ns/1ns
module gls_supervisor_tb;
	logic i_clock = 1'h0, i_rst_n = 1'h0, sat_cmd = 1'h0, rx_cmd = 1'h0, valid_cmd = 1'h0;
	logic i_sat_qualified, i_almanac_rx, i_almanac_valid;
	logic i_lock_hold_wr = 1'h0, i_sync_hold_wr = 1'h0, i_adjust_osc_alarm = 1'h0, i_pps_raw = 1'h0;
	logic [16:0] i_lock_hold_s = 17'h0, i_sync_hold_s = 17'h0;
	logic [15:0] i_cable_delay_command = 16'h0;
	logic i_ref_10mhz = 1'h0, i_tc_pwc_raw = 1'h0, i_tc_am_raw = 1'h0;
	gls_pkg::gls_display_format_command_t i_display_format_command = 3'h0, o_display_format;
	gls_pkg::gls_tc_cfg_t i_tc_cfg = 4'h0, o_tc_cfg_eff;
	gls_pkg::gls_freq_sel_t i_freq_sel = gls_pkg::GLS_FREQ_REF;
	logic o_lock_green, o_sync_green, o_display_all_eights, o_pps, o_freq_out, o_tc_pwc, o_tc_am;
	gls_pkg::gls_alarms_t o_alarms;
	logic [3:0] exp_q[$];
	logic [3:0] st = 4'h0, e;
	int err_count = 0, n_checks = 0, seed = 32'hE32D, r, d, n_hi;

	gls_supervisor #(.TICK_CYCLES(10)) dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_sat_qualified(i_sat_qualified), .i_almanac_rx(i_almanac_rx), .i_almanac_valid(i_almanac_valid),
		.i_lock_hold_wr(i_lock_hold_wr), .i_lock_hold_s(i_lock_hold_s),
		.i_sync_hold_wr(i_sync_hold_wr), .i_sync_hold_s(i_sync_hold_s),
		.i_adjust_osc_alarm(i_adjust_osc_alarm), .i_display_format_command(i_display_format_command),
		.i_pps_raw(i_pps_raw), .i_cable_delay_command(i_cable_delay_command), .i_ref_10mhz(i_ref_10mhz),
		.i_tc_pwc_raw(i_tc_pwc_raw), .i_tc_am_raw(i_tc_am_raw), .i_tc_cfg(i_tc_cfg), .i_freq_sel(i_freq_sel),
		.o_lock_green(o_lock_green), .o_sync_green(o_sync_green), .o_alarms(o_alarms),
		.o_display_all_eights(o_display_all_eights), .o_display_format(o_display_format), .o_pps(o_pps),
		.o_freq_out(o_freq_out), .o_tc_pwc(o_tc_pwc), .o_tc_am(o_tc_am), .o_tc_cfg_eff(o_tc_cfg_eff));
	gls_rx_model #(.LAG(7)) rx_u (.i_clock(i_clock), .i_sat_cmd(sat_cmd), .i_rx_cmd(rx_cmd),
		.i_valid_cmd(valid_cmd), .o_sat_qualified(i_sat_qualified), .o_almanac_rx(i_almanac_rx),
		.o_almanac_valid(i_almanac_valid));

	always #5 i_clock = ~i_clock;

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_checks++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic drain(input int bound);
		repeat (bound) begin
			if (exp_q.size() > 0) @(posedge i_clock);
		end
		if (exp_q.size() > 0) begin
			check(exp_q.size(), 0);
			end_sim();
		end
	endtask

	// output options wander every cycle so all codes reach the checker
	always @(posedge i_clock) begin
		r = $random(seed);
		i_tc_cfg <= r[3:0];
		i_freq_sel <= gls_pkg::gls_freq_sel_t'(r[4]);
		i_ref_10mhz <= r[5];
		i_tc_pwc_raw <= r[6];
		i_tc_am_raw <= r[7];
		i_display_format_command <= r[10:8];
	end

	// sampled on the falling edge so a lamp and its alarm moving together count as one change
	always @(negedge i_clock) begin
		if (i_rst_n && {o_lock_green, o_sync_green, o_alarms} !== st) begin
			st = {o_lock_green, o_sync_green, o_alarms};
			e = exp_q.size() > 0 ? exp_q.pop_front() : 4'hX;
			check(st, e);
		end
	end

	// ----------------------------------------
	// status: {lock, sync, minor, major}
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'h1;
		@(posedge i_clock);
		i_sync_hold_s <= 17'h8;
		i_sync_hold_wr <= 1'h1;
		@(posedge i_clock);
		i_sync_hold_wr <= 1'h0;
		sat_cmd <= 1'h1;
		rx_cmd <= 1'h1;
		exp_q.push_back(4'h8);
		exp_q.push_back(4'hC);
		drain(8000);
		rx_cmd <= 1'h0;
		valid_cmd <= 1'h1;
		sat_cmd <= 1'h0;
		exp_q.push_back(4'h9);
		exp_q.push_back(4'h3);
		drain(9200);
		// almanac lost: lock returns first, sync waits for a full recovery
		valid_cmd <= 1'h0;
		i_adjust_osc_alarm <= 1'h1;
		sat_cmd <= 1'h1;
		rx_cmd <= 1'h1;
		exp_q.push_back(4'h9);
		exp_q.push_back(4'hC);
		@(negedge i_clock);
		check(o_display_all_eights, 0);
		// any 30 cycles of alarm hold exactly ten cycles of eights, whatever the tick phase
		n_hi = 0;
		repeat (30) begin
			@(negedge i_clock);
			if (o_display_all_eights === 1'h1) n_hi++;
		end
		check(n_hi, 10);
		drain(8200);
		i_adjust_osc_alarm <= 1'h0;
		i_lock_hold_s <= 17'h64;
		i_lock_hold_wr <= 1'h1;
		rx_cmd <= 1'h0;
		valid_cmd <= 1'h1;
		sat_cmd <= 1'h0;
		exp_q.push_back(4'h9);
		exp_q.push_back(4'hC);
		@(posedge i_clock);
		i_lock_hold_wr <= 1'h0;
		repeat (110) @(posedge i_clock);
		sat_cmd <= 1'h1;
		drain(800);
		// lock holdover now 100 s: both lamps drop, then return together on a valid almanac
		sat_cmd <= 1'h0;
		exp_q.push_back(4'h9);
		exp_q.push_back(4'h3);
		drain(1300);
		sat_cmd <= 1'h1;
		exp_q.push_back(4'hC);
		drain(800);
		d = ($random(seed) & 7) + 2;
		i_cable_delay_command <= d[15:0];
		repeat (4) @(posedge i_clock);
		i_pps_raw <= 1'h1;
		repeat (d + 1) @(posedge i_clock);
		@(negedge i_clock);
		check(o_pps, 0);
		@(negedge i_clock);
		check(o_pps, 1);
		@(posedge i_clock);
		i_pps_raw <= 1'h0;
		@(negedge i_clock);
		check(o_pps, 1);
		@(negedge i_clock);
		check(o_pps, 0);
		end_sim();
	end
endmodule
